// ---- design/bscan_oe_cells.sv ----
// boundary-scan tap and the output-enable / output / input cells for loop,
// receive and acknowledge pins of an eight-channel line interface
// assumes tck is the JTAG clock from the tester; functional signals live on ref_clk
`timescale 1ns/1ps
// Overview of operation
// - loop drive enable cell at one drives all eight loop pins
// - each driven loop pin follows its loop output cell value
// - enable cell zero floats loop pins; their levels are captured in input cells
// - per channel receive enable high enables pos, neg and clock outputs
// - per channel receive enable low floats pos, neg and clock outputs
// - ack enable cell one drives acknowledge pin from the chain
// - ack enable cell zero floats the acknowledge pin
module bscan_oe_cells
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   // functional side, on ref_clk
   input wire logic [bscan_oe_pkg::LOOP_PINS-1:0] loop_func_out,
   input wire logic [bscan_oe_pkg::LOOP_PINS-1:0] loop_func_oe,
   input wire bscan_oe_pkg::rx_bus_s rx_func,
   input wire logic [bscan_oe_pkg::CHANNELS-1:0] rx_func_oe,
   input wire logic ack_func_n,
   input wire logic ack_func_oe,
   output logic [bscan_oe_pkg::LOOP_PINS-1:0] loop_func_in,
   // pads
   input wire logic [bscan_oe_pkg::LOOP_PINS-1:0] loop_pin_i,
   output logic [bscan_oe_pkg::LOOP_PINS-1:0] loop_pin_o,
   output logic [bscan_oe_pkg::LOOP_PINS-1:0] loop_pin_oe,
   output bscan_oe_pkg::rx_bus_s rx_pin_o,
   output logic [bscan_oe_pkg::CHANNELS-1:0] rx_pin_oe,
   output logic ack_pin_n_o,
   output logic ack_pin_oe,
   output logic extest_active
);
   localparam int N = bscan_oe_pkg::CHAIN_LEN;
   localparam int LP = bscan_oe_pkg::LOOP_PINS;
   localparam int CH = bscan_oe_pkg::CHANNELS;

   // ---------------------------------------------
   // tap controller (tck domain)
   // ---------------------------------------------
   bscan_oe_pkg::tap_state_e state_reg;
   bscan_oe_pkg::tap_state_e state_next;
   logic [bscan_oe_pkg::IR_WIDTH-1:0] ir_shift_reg;
   logic [bscan_oe_pkg::IR_WIDTH-1:0] ir_reg;
   logic [N-1:0] shift_reg;
   logic [N-1:0] update_reg;
   logic bypass_reg;
   logic tdo_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         bscan_oe_pkg::TAP_RESET:
            state_next = tms ? bscan_oe_pkg::TAP_RESET : bscan_oe_pkg::TAP_IDLE;
         bscan_oe_pkg::TAP_IDLE:
            state_next = tms ? bscan_oe_pkg::TAP_SEL_DR : bscan_oe_pkg::TAP_IDLE;
         bscan_oe_pkg::TAP_SEL_DR:
            state_next = tms ? bscan_oe_pkg::TAP_SEL_IR : bscan_oe_pkg::TAP_CAP_DR;
         bscan_oe_pkg::TAP_CAP_DR:
            state_next = tms ? bscan_oe_pkg::TAP_EXIT1_DR : bscan_oe_pkg::TAP_SHIFT_DR;
         bscan_oe_pkg::TAP_SHIFT_DR:
            state_next = tms ? bscan_oe_pkg::TAP_EXIT1_DR : bscan_oe_pkg::TAP_SHIFT_DR;
         bscan_oe_pkg::TAP_EXIT1_DR:
            state_next = tms ? bscan_oe_pkg::TAP_UPD_DR : bscan_oe_pkg::TAP_PAUSE_DR;
         bscan_oe_pkg::TAP_PAUSE_DR:
            state_next = tms ? bscan_oe_pkg::TAP_EXIT2_DR : bscan_oe_pkg::TAP_PAUSE_DR;
         bscan_oe_pkg::TAP_EXIT2_DR:
            state_next = tms ? bscan_oe_pkg::TAP_UPD_DR : bscan_oe_pkg::TAP_SHIFT_DR;
         bscan_oe_pkg::TAP_UPD_DR:
            state_next = tms ? bscan_oe_pkg::TAP_SEL_DR : bscan_oe_pkg::TAP_IDLE;
         bscan_oe_pkg::TAP_SEL_IR:
            state_next = tms ? bscan_oe_pkg::TAP_RESET : bscan_oe_pkg::TAP_CAP_IR;
         bscan_oe_pkg::TAP_CAP_IR:
            state_next = tms ? bscan_oe_pkg::TAP_EXIT1_IR : bscan_oe_pkg::TAP_SHIFT_IR;
         bscan_oe_pkg::TAP_SHIFT_IR:
            state_next = tms ? bscan_oe_pkg::TAP_EXIT1_IR : bscan_oe_pkg::TAP_SHIFT_IR;
         bscan_oe_pkg::TAP_EXIT1_IR:
            state_next = tms ? bscan_oe_pkg::TAP_UPD_IR : bscan_oe_pkg::TAP_PAUSE_IR;
         bscan_oe_pkg::TAP_PAUSE_IR:
            state_next = tms ? bscan_oe_pkg::TAP_EXIT2_IR : bscan_oe_pkg::TAP_PAUSE_IR;
         bscan_oe_pkg::TAP_EXIT2_IR:
            state_next = tms ? bscan_oe_pkg::TAP_UPD_IR : bscan_oe_pkg::TAP_SHIFT_IR;
         bscan_oe_pkg::TAP_UPD_IR:
            state_next = tms ? bscan_oe_pkg::TAP_SEL_DR : bscan_oe_pkg::TAP_IDLE;
         default:
            state_next = bscan_oe_pkg::TAP_RESET;
      endcase
   end

   wire in_reset = (state_reg == bscan_oe_pkg::TAP_RESET);
   wire cap_dr = (state_reg == bscan_oe_pkg::TAP_CAP_DR);
   wire shift_dr = (state_reg == bscan_oe_pkg::TAP_SHIFT_DR);
   wire upd_dr = (state_reg == bscan_oe_pkg::TAP_UPD_DR);
   wire cap_ir = (state_reg == bscan_oe_pkg::TAP_CAP_IR);
   wire shift_ir = (state_reg == bscan_oe_pkg::TAP_SHIFT_IR);
   wire upd_ir = (state_reg == bscan_oe_pkg::TAP_UPD_IR);
   wire sel_extest = (ir_reg == bscan_oe_pkg::IR_EXTEST);
   wire sel_chain = sel_extest || (ir_reg == bscan_oe_pkg::IR_SAMPLE);

   // ---------------------------------------------
   // capture values: pin levels as seen in tck domain
   // ---------------------------------------------
   logic [2*LP-1:0] pin_tck;
   logic [N-1:0] capture_vec;

   // pad levels and the ref_clk drive enables are asynchronous to tck, so both are
   // synchronised before capture; tck must run two edges after the pads settle
   level_sync #(.WIDTH(2*LP)) u_loop_sync
   (
      .clk(tck),
      .rst_n(trst_n),
      .d({loop_pin_oe, loop_pin_i}),
      .q(pin_tck)
   );

   genvar g;
   generate
      for (g = 0; g < LP; g++)
      begin : g_loop_cap
         // tristate cell reports the pin's inverted drive enable (one when floating), input cell the pad level
         assign capture_vec[bscan_oe_pkg::POS_LOOP_BASE + 3*g] = ~pin_tck[LP+g];
         assign capture_vec[bscan_oe_pkg::POS_LOOP_BASE + 3*g + 1] = pin_tck[g];
         assign capture_vec[bscan_oe_pkg::POS_LOOP_BASE + 3*g + 2] =
            update_reg[bscan_oe_pkg::POS_LOOP_BASE + 3*g + 2];
      end
      // output and enable cells recapture their own update value, keeping them stable
      for (g = bscan_oe_pkg::POS_LOOP_EN; g < N; g++)
      begin : g_other_cap
         assign capture_vec[g] = update_reg[g];
      end
   endgenerate

   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
         state_reg <= bscan_oe_pkg::TAP_RESET;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         ir_shift_reg <= bscan_oe_pkg::IR_CAPTURE_VALUE;
         ir_reg <= bscan_oe_pkg::IR_BYPASS;
      end
      else if (in_reset)
         ir_reg <= bscan_oe_pkg::IR_BYPASS;
      else if (cap_ir)
         ir_shift_reg <= bscan_oe_pkg::IR_CAPTURE_VALUE;
      else if (shift_ir)
         ir_shift_reg <= {tdi, ir_shift_reg[bscan_oe_pkg::IR_WIDTH-1:1]};
      else if (upd_ir)
         ir_reg <= ir_shift_reg;
   end

   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         shift_reg <= bscan_oe_pkg::CHAIN_RESET;
         bypass_reg <= 1'b0;
      end
      else if (cap_dr)
      begin
         if (sel_chain)
            shift_reg <= capture_vec;
         bypass_reg <= 1'b0;
      end
      else if (shift_dr)
      begin
         if (sel_chain)
            shift_reg <= {tdi, shift_reg[N-1:1]};
         bypass_reg <= tdi;
      end
   end

   // update latches change only on update-dr or in test-logic-reset, so shifting never disturbs the pins
   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
         update_reg <= bscan_oe_pkg::CHAIN_RESET;
      else if (in_reset)
         update_reg <= bscan_oe_pkg::CHAIN_RESET;
      else if (upd_dr && sel_chain)
         update_reg <= shift_reg;
   end

   always_ff @(negedge tck or negedge trst_n)
   begin
      if (!trst_n)
         tdo_reg <= 1'b0;
      else if (shift_ir)
         tdo_reg <= ir_shift_reg[0];
      else if (sel_chain)
         tdo_reg <= shift_reg[0];
      else
         tdo_reg <= bypass_reg;
   end

   // ---------------------------------------------
   // crossing to ref_clk
   // ---------------------------------------------
   // update bits and the extest flag change only at update-dr/ir or in test-logic-reset; the synchronised
   // word is taken only when two successive samples agree, so bits that straddle a
   // ref_clk edge never reach the pins as a mixed word (costs two extra cycles)
   logic [N:0] scan_sync;
   logic [N:0] scan_prev_reg;
   logic [N:0] scan_hold_reg;

   level_sync #(.WIDTH(N+1)) u_upd_sync
   (
      .clk(ref_clk),
      .rst_n(resetn),
      .d({sel_extest, update_reg}),
      .q(scan_sync)
   );

   wire scan_agree = (scan_sync == scan_prev_reg);

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scan_prev_reg <= '0;
         scan_hold_reg <= '0;
      end
      else
      begin
         scan_prev_reg <= scan_sync;
         if (scan_agree)
            scan_hold_reg <= scan_sync;
      end
   end

   wire [N:0] scan_ref = scan_hold_reg;

   wire ext_ref = scan_ref[N];
   wire scan_loop_en = scan_ref[bscan_oe_pkg::POS_LOOP_EN];
   wire scan_ack_out = scan_ref[bscan_oe_pkg::POS_ACK_OUT];
   wire scan_ack_en = scan_ref[bscan_oe_pkg::POS_ACK_EN];
   logic [LP-1:0] scan_loop_val;
   logic [CH-1:0] scan_rx_en;
   bscan_oe_pkg::rx_bus_s scan_rx;

   generate
      for (g = 0; g < LP; g++)
      begin : g_loop_sel
         assign scan_loop_val[g] = scan_ref[bscan_oe_pkg::POS_LOOP_BASE + 3*g + 2];
      end
      for (g = 0; g < CH; g++)
      begin : g_rx_sel
         assign scan_rx.clk[g] = scan_ref[bscan_oe_pkg::POS_RX_BASE + 4*g];
         assign scan_rx.pos[g] = scan_ref[bscan_oe_pkg::POS_RX_BASE + 4*g + 1];
         assign scan_rx.neg[g] = scan_ref[bscan_oe_pkg::POS_RX_BASE + 4*g + 2];
         assign scan_rx_en[g] = scan_ref[bscan_oe_pkg::POS_RX_BASE + 4*g + 3];
      end
   endgenerate

   // ---------------------------------------------
   // pin multiplexing (ref_clk, registered outputs)
   // ---------------------------------------------
   logic [LP-1:0] loop_in_meta_reg;
   wire [LP-1:0] loop_o_next = ext_ref ? scan_loop_val : loop_func_out;
   wire [LP-1:0] loop_oe_next = ext_ref ? {LP{scan_loop_en}} : loop_func_oe;
   wire [CH-1:0] rx_oe_next = ext_ref ? scan_rx_en : rx_func_oe;
   wire bscan_oe_pkg::rx_bus_s rx_o_next = ext_ref ? scan_rx : rx_func;
   wire ack_o_next = ext_ref ? scan_ack_out : ack_func_n;
   wire ack_oe_next = ext_ref ? scan_ack_en : ack_func_oe;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         loop_pin_o <= '0;
         loop_pin_oe <= '0;
         rx_pin_o <= '0;
         rx_pin_oe <= '0;
         ack_pin_n_o <= 1'b1;
         ack_pin_oe <= 1'b0;
         extest_active <= 1'b0;
      end
      else
      begin
         loop_pin_o <= loop_o_next;
         loop_pin_oe <= loop_oe_next;
         rx_pin_o <= rx_o_next;
         rx_pin_oe <= rx_oe_next;
         ack_pin_n_o <= ack_o_next;
         ack_pin_oe <= ack_oe_next;
         extest_active <= ext_ref;
      end
   end

   // functional readback of loop pins, synchronised since pads are asynchronous
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         loop_in_meta_reg <= '0;
         loop_func_in <= '0;
      end
      else
      begin
         loop_in_meta_reg <= loop_pin_i;
         loop_func_in <= loop_in_meta_reg;
      end
   end

   assign tdo = tdo_reg;
endmodule

// ---- design/bscan_oe_pkg.sv ----
// package for the boundary-scan output-enable cell block
// assumes a JTAG controller outside drives the standard tck/tms/tdi/trst pins
package bscan_oe_pkg;
   localparam int CHANNELS = 8;
   localparam int LOOP_PINS = 8;
   localparam int IR_WIDTH = 4;
   // instruction codes (opcodes are a local choice)
   localparam logic [3:0] IR_EXTEST = 4'h0;
   localparam logic [3:0] IR_SAMPLE = 4'h1;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_RESET = 4'h1;
   localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
   // chain length: loop tri, in, out per pin, loop enable, 4 per channel, ack out, ack enable
   localparam int CHAIN_LEN = LOOP_PINS * 3 + 1 + CHANNELS * 4 + 2;
   // cell positions in the chain
   localparam int POS_LOOP_BASE = 0;
   localparam int POS_LOOP_EN = LOOP_PINS * 3;
   localparam int POS_RX_BASE = POS_LOOP_EN + 1;
   localparam int POS_ACK_OUT = POS_RX_BASE + CHANNELS * 4;
   localparam int POS_ACK_EN = POS_ACK_OUT + 1;
   localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = '0;

   typedef enum logic [3:0]
   {
      TAP_RESET = 4'h0,
      TAP_IDLE = 4'h1,
      TAP_SEL_DR = 4'h2,
      TAP_CAP_DR = 4'h3,
      TAP_SHIFT_DR = 4'h4,
      TAP_EXIT1_DR = 4'h5,
      TAP_PAUSE_DR = 4'h6,
      TAP_EXIT2_DR = 4'h7,
      TAP_UPD_DR = 4'h8,
      TAP_SEL_IR = 4'h9,
      TAP_CAP_IR = 4'hA,
      TAP_SHIFT_IR = 4'hB,
      TAP_EXIT1_IR = 4'hC,
      TAP_PAUSE_IR = 4'hD,
      TAP_EXIT2_IR = 4'hE,
      TAP_UPD_IR = 4'hF
   } tap_state_e;

   typedef struct packed
   {
      logic [CHANNELS-1:0] pos;
      logic [CHANNELS-1:0] neg;
      logic [CHANNELS-1:0] clk;
   } rx_bus_s;
endpackage

// ---- design/level_sync.sv ----
// two-flop synchroniser for a bus of levels
// assumes the inputs are quasi-static or gray with respect to clk
`timescale 1ns/1ps
module level_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ---- dv/bscan_oe_chk.sv ----
// checker for the scan output-enable cells, watching the top ports only
// assumes the bind below attaches it to every bscan_oe_cells instance
`timescale 1ns/1ps
module bscan_oe_chk
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] loop_func_out,
   input wire logic [7:0] loop_func_oe,
   input wire bscan_oe_pkg::rx_bus_s rx_func,
   input wire logic [7:0] rx_func_oe,
   input wire logic ack_func_n,
   input wire logic ack_func_oe,
   input wire logic [7:0] loop_func_in,
   input wire logic [7:0] loop_pin_i,
   input wire logic [7:0] loop_pin_o,
   input wire logic [7:0] loop_pin_oe,
   input wire bscan_oe_pkg::rx_bus_s rx_pin_o,
   input wire logic [7:0] rx_pin_oe,
   input wire logic ack_pin_n_o,
   input wire logic ack_pin_oe,
   input wire logic extest_active
);
   logic [2:0] up_cnt;
   logic [49:0] func_all;
   assign func_all = {loop_func_out, loop_func_oe, rx_func, rx_func_oe, ack_func_n, ack_func_oe};
   // pins lag a reset or a mode change by a few cycles, so wait before judging
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         up_cnt <= 3'h0;
      else if (up_cnt != 3'h7)
         up_cnt <= up_cnt + 3'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_ext;
      (up_cnt > 3'h3 && extest_active) [*3];
   endsequence
   sequence s_func;
      (up_cnt > 3'h3 && !extest_active && $stable(func_all)) [*3];
   endsequence
   sequence s_ext_poke;
      s_ext ##0 $changed(func_all);
   endsequence
   a_loop_oe_whole: assert property (s_ext |->
      loop_pin_oe == 8'h00 || loop_pin_oe == 8'hFF)
      else $error("loop pins not switched as one group");
   a_func_loop: assert property (s_func |->
      loop_pin_oe == loop_func_oe && loop_pin_o == loop_func_out)
      else $error("loop pins do not follow functional side");
   a_func_rx: assert property (s_func |->
      rx_pin_oe == rx_func_oe && rx_pin_o == rx_func)
      else $error("receive pins do not follow functional side");
   a_func_ack: assert property (s_func |->
      ack_pin_oe == ack_func_oe && ack_pin_n_o == ack_func_n)
      else $error("ack pin does not follow functional side");
   a_pin_in_sync: assert property ((up_cnt > 3'h3 && $stable(loop_pin_i)) [*3] |->
      loop_func_in == loop_pin_i)
      else $error("loop pin level not passed inward");
   a_ext_loop_hold: assert property (s_ext_poke |=>
      $stable({loop_pin_oe, loop_pin_o}) [*3])
      else $error("loop pins moved by functional side under scan");
   a_ext_rx_hold: assert property (s_ext_poke |=>
      $stable({rx_pin_oe, rx_pin_o}) [*3])
      else $error("receive pins moved by functional side under scan");
   a_ext_ack_hold: assert property (s_ext_poke |=>
      $stable({ack_pin_oe, ack_pin_n_o}) [*3])
      else $error("ack pin moved by functional side under scan");
endmodule
bind bscan_oe_cells bscan_oe_chk u_chk
(
   .ref_clk(ref_clk), .resetn(resetn), .loop_func_out(loop_func_out),
   .loop_func_oe(loop_func_oe), .rx_func(rx_func), .rx_func_oe(rx_func_oe),
   .ack_func_n(ack_func_n), .ack_func_oe(ack_func_oe), .loop_func_in(loop_func_in),
   .loop_pin_i(loop_pin_i), .loop_pin_o(loop_pin_o), .loop_pin_oe(loop_pin_oe),
   .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe), .ack_pin_n_o(ack_pin_n_o),
   .ack_pin_oe(ack_pin_oe), .extest_active(extest_active)
);

// ---- dv/jtag_model.sv ----
// behavioural test controller walking the tap for instruction and data scans
// assumes the device samples tms/tdi on rising tck and moves tdo on falling tck
`timescale 1ns/1ps
module jtag_model
(
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   input wire logic tdo
);
   logic smp;
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b0;
   end
   // tck only runs inside a scan; idle tdi is flipped so nothing leans on a stale bit
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      #40 tck = 1'b1;
      smp = tdo;
      #40 tck = 1'b0;
   endtask
   task automatic tap_reset;
      #13 trst_n = 1'b0;
      #100 trst_n = 1'b1;
      #20 step(1'b0, ~tdi);
   endtask
   task automatic ir(input logic [3:0] op);
      #7 step(1'b1, ~tdi);
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      for (int i = 0; i < 4; i++)
         step(i == 3, op[i]);
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
   endtask
   task automatic dr(input logic [58:0] d, output logic [58:0] q);
      // two idle clocks let the tck-side pin synchroniser see settled pads before capture
      #7 step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      for (int i = 0; i < 59; i++)
      begin
         step(i == 58, d[i]);
         q[i] = smp;
      end
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
   endtask
endmodule

// ---- dv/test_bscan_oe_cells.sv ----
// self-checking bench for the scan output-enable cells
// assumes jtag_model runs the tap and the bench plays the far end of the loop pins
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_bscan_oe_cells;
   logic ref_clk, resetn, tck, tms, tdi, trst_n, tdo, f_ackn, f_ackoe, p_ackn, p_ackoe, ext_act;
   logic [7:0] f_out, f_oe, f_rxoe, f_in, p_o, p_oe, p_rxoe, ext_drv, pad_i;
   bscan_oe_pkg::rx_bus_s f_rx, p_rx;
   logic [58:0] q;
   int n_fail, check_count;
   assign pad_i = (p_oe & p_o) | (~p_oe & ext_drv);
   bscan_oe_cells dut
   (
      .ref_clk(ref_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo(tdo), .loop_func_out(f_out), .loop_func_oe(f_oe), .rx_func(f_rx),
      .rx_func_oe(f_rxoe), .ack_func_n(f_ackn), .ack_func_oe(f_ackoe), .loop_func_in(f_in),
      .loop_pin_i(pad_i), .loop_pin_o(p_o), .loop_pin_oe(p_oe), .rx_pin_o(p_rx),
      .rx_pin_oe(p_rxoe), .ack_pin_n_o(p_ackn), .ack_pin_oe(p_ackoe), .extest_active(ext_act)
   );
   jtag_model u_jtag (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   function automatic logic [58:0] mk(input logic en, input logic [7:0] lo, rxe, rxd,
      input logic ae, av);
      logic [58:0] v;
      v = '0;
      for (int i = 0; i < 8; i++)
      begin
         v[3*i+2] = lo[i];
         v[25+4*i] = rxd[i];
         v[26+4*i] = ~rxd[i];
         v[27+4*i] = rxd[i];
         v[28+4*i] = rxe[i];
      end
      v[24] = en;
      v[57] = av;
      v[58] = ae;
      return v;
   endfunction
   task automatic wt;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask
   task automatic pins(input logic [7:0] oe, o, rxoe, input logic [23:0] rx, input logic aoe, an);
      `CHK(p_oe, oe)
      `CHK(p_o, o)
      `CHK(p_rxoe, rxoe)
      `CHK(p_rx, rx)
      `CHK(p_ackoe, aoe)
      `CHK(p_ackn, an)
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      resetn = 1'b0;
      {f_out, f_oe, f_rxoe, f_ackn, f_ackoe} = {8'h3C, 8'hF0, 8'h0F, 1'b0, 1'b1};
      f_rx = 24'h112244;
      ext_drv = 8'h5A;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      u_jtag.tap_reset();
      wt();
      pins(8'hF0, 8'h3C, 8'h0F, 24'h112244, 1'b1, 1'b0);
      $display("test functional done");
      u_jtag.ir(bscan_oe_pkg::IR_EXTEST);
      u_jtag.dr(mk(1'b1, 8'hA5, 8'h3C, 8'h96, 1'b1, 1'b0), q);
      wt();
      `CHK(ext_act, 1'b1)
      pins(8'hFF, 8'hA5, 8'h3C, 24'h699696, 1'b1, 1'b0);
      `CHK(f_in, 8'hA5)
      @(posedge ref_clk);
      {f_oe, f_rxoe, f_ackoe} <= {8'h0F, 8'hF0, 1'b0};
      wt();
      pins(8'hFF, 8'hA5, 8'h3C, 24'h699696, 1'b1, 1'b0);
      $display("test scan drive done");
      u_jtag.dr(mk(1'b0, 8'hFF, 8'hC3, 8'h00, 1'b0, 1'b1), q);
      wt();
      pins(8'h00, 8'hFF, 8'hC3, 24'hFF0000, 1'b0, 1'b1);
      `CHK(f_in, 8'h5A)
      u_jtag.dr(mk(1'b0, 8'hFF, 8'hC3, 8'h00, 1'b0, 1'b1), q);
      for (int i = 0; i < 8; i++)
      begin
         `CHK(q[3*i+1], ext_drv[i])
         `CHK(q[3*i], 1'b1)
      end
      `CHK({q[58], q[24], q[28]}, 3'h1)
      $display("test scan float done");
      u_jtag.ir(bscan_oe_pkg::IR_SAMPLE);
      u_jtag.dr(mk(1'b1, 8'h00, 8'hFF, 8'hFF, 1'b1, 1'b1), q);
      wt();
      `CHK(ext_act, 1'b0)
      pins(8'h0F, 8'h3C, 8'hF0, 24'h112244, 1'b0, 1'b0);
      $display("test sample done");
      u_jtag.ir(bscan_oe_pkg::IR_BYPASS);
      u_jtag.dr(59'h35A5A5A5A5A5A5A, q);
      `CHK(q, 59'h6B4B4B4B4B4B4B4)
      wt();
      `CHK(ext_act, 1'b0)
      pins(8'h0F, 8'h3C, 8'hF0, 24'h112244, 1'b0, 1'b0);
      $display("test bypass done");
      finish_test();
   end
endmodule
